// *** rtl/fsw_defines.svh ***
/*
 * constants for the frequency select / watchdog recovery block.
 * assumes inclusion by bare name from rtl files; definitions only.
 */
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH

// ****************************************************************
// field widths, divider offset and strap wait
// ****************************************************************
`define FSW_SEL_W        5
`define FSW_N_W          8
`define FSW_M_W          7
`define FSW_DIV_OFFSET   9'h003
`define FSW_STRAP_WAIT   2'h2
// ****************************************************************
// watchdog timing
// ****************************************************************
`define FSW_WD_SHORT_MS  150
`define FSW_WD_LONG_MS   2500
`define FSW_CLK_MHZ      100
`define FSW_US_PER_MS    1000
`define FSW_RST_PULSE    8'h10

`endif

// *** rtl/fsw_pkg.sv ***
/*
 * types for the frequency select / watchdog recovery block.
 * assumes fsw_defines.svh is on the include path.
 */
package fsw_pkg;
   // source that currently sets the cpu frequency
   typedef enum logic [1:0]
   {
      FSW_SRC_STRAP = 2'b00,
      FSW_SRC_TABLE = 2'b01,
      FSW_SRC_PROG  = 2'b10,
      FSW_SRC_RECOV = 2'b11
   } fsw_src_type;

   // watchdog states
   typedef enum logic [1:0]
   {
      FSW_WD_IDLE  = 2'b00,
      FSW_WD_WAIT  = 2'b01,
      FSW_WD_COUNT = 2'b10,
      FSW_WD_DONE  = 2'b11
   } fsw_wd_type;
endpackage

// *** rtl/fsw_freq_ctrl.sv ***
/*
 * frequency select and watchdog recovery control.
 * assumes a serial bus slave on mclk_i presents register values as levels
 * plus one-cycle write strobes and a transaction-end pulse.
 */
// Behaviour
// - divider mode covers 50 to 248 MHz
// - programmable enable resets to disabled
// - straps set frequency when not overridden
// - override uses programmed table select
// - programmable mode uses N, M, gear
// - gear and ratio follow override choice
// - cpu N is 8 bits, M 7
// - cpu N or M update starts load
// - recovery select: straps or recovery dividers
// - time-out switches to recovery automatically
// - recovery N/M fields; update starts load
// - recovery ratio follows override choice
// - arm cleared stops and reloads counter
// - armed watchdog counts after frequency change
// - time-out resets system, activates recovery
// - frequency is G times (N+3)/(M+3)
// - time-out reset pulse gated by enable
// - change reset pulse gated by enable
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defines.svh"

module fsw_freq_ctrl
   import fsw_pkg::*;
#(
   // start values in clock cycles; the products stay inside a 32-bit int
   parameter int WD_SHORT_CYC = `FSW_WD_SHORT_MS * `FSW_US_PER_MS * `FSW_CLK_MHZ,
   parameter int WD_LONG_CYC  = `FSW_WD_LONG_MS * `FSW_US_PER_MS * `FSW_CLK_MHZ
)
(
   input  wire logic                  mclk_i,
   input  wire logic                  rst_i,
   input  wire logic [`FSW_SEL_W-1:0] latched_strap_inputs_i,
   input  wire logic                  prog_enable_i,
   input  wire logic                  strap_bypass_select_i,
   input  wire logic [`FSW_SEL_W-1:0] table_select_i,
   input  wire logic [`FSW_N_W-1:0]   cpu_divider_n_i,
   input  wire logic [`FSW_M_W-1:0]   cpu_divider_m_i,
   input  wire logic                  cpu_div_wr_i,
   input  wire logic                  recovery_source_select_i,
   input  wire logic [`FSW_N_W-1:0]   recovery_divider_n_i,
   input  wire logic [`FSW_M_W-1:0]   recovery_divider_m_i,
   input  wire logic                  rec_div_wr_i,
   input  wire logic                  bus_done_i,
   input  wire logic                  watchdog_arm_i,
   input  wire logic                  wd_long_scale_i,
   input  wire logic                  timeout_reset_enable_i,
   input  wire logic                  change_reset_enable_i,
   output logic [1:0]                 freq_source_o,
   output logic [`FSW_SEL_W-1:0]      ratio_select_o,
   output logic [`FSW_N_W:0]          pll_num_o,
   output logic [`FSW_N_W:0]          pll_den_o,
   output logic                       freq_load_o,
   output logic                       recovery_active_o,
   output logic                       wd_timeout_o,
   output logic                       sys_reset_o
);

   // ****************************************************************
   // strap synchronisers
   // ****************************************************************
   // straps come from pins, so two stages before anything looks at them
   logic [`FSW_SEL_W-1:0] strap_s1_reg;
   logic [`FSW_SEL_W-1:0] strap_s2_reg;
   logic [`FSW_SEL_W-1:0] strap_latch_reg;
   logic [1:0]            strap_cnt_reg;
   logic                  strap_done_reg;

   always_ff @(posedge mclk_i)
   begin
      strap_s1_reg <= latched_strap_inputs_i;
      strap_s2_reg <= strap_s1_reg;
   end

   // straps caught once after reset release, when the chain is settled
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == `FSW_STRAP_WAIT)
         begin
            strap_latch_reg <= strap_s2_reg;
            strap_done_reg  <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // divider shadow registers
   // ****************************************************************
   // pending writes become live only at transaction end, so both
   // halves of a pair change together
   logic [`FSW_N_W-1:0] cpu_n_reg;
   logic [`FSW_M_W-1:0] cpu_m_reg;
   logic [`FSW_N_W-1:0] rec_n_reg;
   logic [`FSW_M_W-1:0] rec_m_reg;
   logic                cpu_pend_reg;
   logic                rec_pend_reg;
   wire                 cpu_apply = (cpu_pend_reg || cpu_div_wr_i) && bus_done_i;
   wire                 rec_apply = (rec_pend_reg || rec_div_wr_i) && bus_done_i;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         cpu_n_reg    <= {`FSW_N_W{1'b0}};
         cpu_m_reg    <= {`FSW_M_W{1'b0}};
         rec_n_reg    <= {`FSW_N_W{1'b0}};
         rec_m_reg    <= {`FSW_M_W{1'b0}};
         cpu_pend_reg <= 1'b0;
         rec_pend_reg <= 1'b0;
      end
      else
      begin
         // a write landing with the end is applied at once, so an end
         // never leaves a stale pair to be applied again later
         cpu_pend_reg <= (cpu_div_wr_i || cpu_pend_reg) && !bus_done_i;
         rec_pend_reg <= (rec_div_wr_i || rec_pend_reg) && !bus_done_i;
         if (cpu_apply)
         begin
            cpu_n_reg <= cpu_divider_n_i;
            cpu_m_reg <= cpu_divider_m_i;
         end
         if (rec_apply)
         begin
            rec_n_reg <= recovery_divider_n_i;
            rec_m_reg <= recovery_divider_m_i;
         end
      end
   end

   // ****************************************************************
   // frequency source selection
   // ****************************************************************
   logic        recov_reg;
   fsw_src_type src_next;
   logic [`FSW_SEL_W-1:0] ratio_next;
   logic [`FSW_N_W:0]     num_next;
   logic [`FSW_N_W:0]     den_next;

   // gear and ratio always follow the override choice
   assign ratio_next = strap_bypass_select_i ? table_select_i
                                             : strap_latch_reg;

   // recovery wins, then divider mode, then table or strap
   assign src_next = recov_reg ? FSW_SRC_RECOV
                   : prog_enable_i ? FSW_SRC_PROG
                   : strap_bypass_select_i ? FSW_SRC_TABLE
                   : FSW_SRC_STRAP;

   // recovery from straps uses the table path, otherwise the divider pair;
   // the pll multiplies gear by num/den, num and den carrying the +3
   // offset; software keeps num above den for the 50..248 MHz span
   wire use_rec_div = recov_reg && recovery_source_select_i;
   assign num_next = use_rec_div ? {1'b0, rec_n_reg} + `FSW_DIV_OFFSET
                   : {1'b0, cpu_n_reg} + `FSW_DIV_OFFSET;
   assign den_next = use_rec_div ? {2'b00, rec_m_reg} + `FSW_DIV_OFFSET
                   : {2'b00, cpu_m_reg} + `FSW_DIV_OFFSET;

   // a frequency change is any new effective setting or an update of the divider pair in use
   logic [1:0]            src_q_reg;
   logic [`FSW_SEL_W-1:0] ratio_q_reg;
   logic [`FSW_N_W:0]     num_q_reg;
   logic [`FSW_N_W:0]     den_q_reg;
   wire src_changed = (src_next != src_q_reg) || (ratio_next != ratio_q_reg);
   wire div_changed = (num_next != num_q_reg) || (den_next != den_q_reg);
   wire div_in_use  = (src_next == FSW_SRC_PROG) || use_rec_div;
   wire freq_change = strap_done_reg
                   && (src_changed || (div_in_use && div_changed)
                       || (cpu_apply && src_next == FSW_SRC_PROG)
                       || (rec_apply && use_rec_div));

   // output register bank; all outputs straight from flops
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         // divider mode is off out of reset, so the straps lead
         src_q_reg   <= FSW_SRC_STRAP;
         ratio_q_reg <= {`FSW_SEL_W{1'b0}};
         num_q_reg   <= `FSW_DIV_OFFSET;
         den_q_reg   <= `FSW_DIV_OFFSET;
         freq_load_o <= 1'b0;
      end
      else
      begin
         src_q_reg   <= src_next;
         ratio_q_reg <= ratio_next;
         num_q_reg   <= num_next;
         den_q_reg   <= den_next;
         freq_load_o <= freq_change;
      end
   end

   // outputs mirror the registered bank; no logic between flop and pin
   assign freq_source_o     = src_q_reg;
   assign ratio_select_o    = ratio_q_reg;
   assign pll_num_o         = num_q_reg;
   assign pll_den_o         = den_q_reg;
   assign recovery_active_o = recov_reg;

   // ****************************************************************
   // watchdog
   // ****************************************************************
   fsw_wd_type wd_state_reg;
   fsw_wd_type wd_state_next;
   logic [31:0] wd_cnt_reg;
   logic [31:0] wd_cnt_next;
   wire  [31:0] wd_start = wd_long_scale_i ? WD_LONG_CYC[31:0] : WD_SHORT_CYC[31:0];
   // firing needs arm still high, so a disarm on the last count wins
   wire         wd_fire  = (wd_state_reg == FSW_WD_COUNT) && (wd_cnt_reg == 32'h1)
                        && watchdog_arm_i;

   // wait for a change before counting, so an armed but quiet
   // system never times out on its own
   always_comb
   begin
      wd_state_next = wd_state_reg;
      wd_cnt_next   = wd_cnt_reg;
      case (wd_state_reg)
         FSW_WD_IDLE:
         begin
            wd_cnt_next = wd_start;
            if (watchdog_arm_i)
               wd_state_next = FSW_WD_WAIT;
         end
         FSW_WD_WAIT:
         begin
            wd_cnt_next = wd_start;
            if (freq_change)
               wd_state_next = FSW_WD_COUNT;
         end
         FSW_WD_COUNT:
         begin
            wd_cnt_next = wd_cnt_reg - 32'h1;
            if (wd_fire)
               wd_state_next = FSW_WD_DONE;
         end
         FSW_WD_DONE:
            wd_state_next = FSW_WD_DONE;
         default:
            wd_state_next = FSW_WD_IDLE;
      endcase
      // clearing arm stops and reloads from any state
      if (!watchdog_arm_i)
      begin
         wd_state_next = FSW_WD_IDLE;
         wd_cnt_next   = wd_start;
      end
   end

   // reset pulse stretched so the system sees a usable width
   logic [7:0] rst_cnt_reg;
   wire        rst_trigger = (wd_fire && timeout_reset_enable_i)
                          || (freq_change && change_reset_enable_i);

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wd_state_reg <= FSW_WD_IDLE;
         wd_cnt_reg   <= 32'h0;
         recov_reg    <= 1'b0;
         wd_timeout_o <= 1'b0;
         rst_cnt_reg  <= 8'h00;
         sys_reset_o  <= 1'b0;
      end
      else
      begin
         wd_state_reg <= wd_state_next;
         wd_cnt_reg   <= wd_cnt_next;
         // recovery holds until the watchdog is disarmed
         if (wd_fire)
            recov_reg <= 1'b1;
         else if (!watchdog_arm_i)
            recov_reg <= 1'b0;
         wd_timeout_o <= wd_fire;
         if (rst_trigger)
            rst_cnt_reg <= `FSW_RST_PULSE;
         else if (rst_cnt_reg != 8'h00)
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
         sys_reset_o <= rst_trigger || (rst_cnt_reg > 8'h01);
      end
   end

endmodule // fsw_freq_ctrl
`default_nettype wire

// *** bench/fsw_freq_ctrl_assertions.sv ***
/* checker for fsw_freq_ctrl ports.
   assumes binding to the top module, sim counts set small. */
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defines.svh"
module fsw_freq_ctrl_assertions #(
   parameter int WD_SHORT_CYC = 50,
   parameter int WD_LONG_CYC  = 80
)
(
   input wire logic mclk_i, rst_i, prog_enable_i, strap_bypass_select_i, cpu_div_wr_i,
   input wire logic recovery_source_select_i, rec_div_wr_i, bus_done_i, watchdog_arm_i,
   input wire logic wd_long_scale_i, timeout_reset_enable_i, change_reset_enable_i,
   input wire logic [`FSW_SEL_W-1:0] latched_strap_inputs_i, table_select_i,
   input wire logic [`FSW_N_W-1:0] cpu_divider_n_i, recovery_divider_n_i,
   input wire logic [`FSW_M_W-1:0] cpu_divider_m_i, recovery_divider_m_i,
   input wire logic [1:0] freq_source_o,
   input wire logic [`FSW_SEL_W-1:0] ratio_select_o,
   input wire logic [`FSW_N_W:0] pll_num_o, pll_den_o,
   input wire logic freq_load_o, recovery_active_o, wd_timeout_o, sys_reset_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ****************************************************************
   // properties
   // ****************************************************************
   // reset pulse holds well past its rising edge
   sequence s_pulse_held;
      sys_reset_o[*8];
   endsequence
   // recovery flag and recovery source both in place
   sequence s_recov_entered;
      recovery_active_o && freq_source_o == 2'b11;
   endsequence
   a_load_after_done: assert property (
      cpu_div_wr_i && bus_done_i && freq_source_o == 2'b10 |=> freq_load_o)
      else $error("no load after divider write");
   // the live pair may move only two cycles after a transaction end
   a_pll_hold_idle: assert property (
      freq_source_o == 2'b10 && $past(freq_source_o) == 2'b10 && !$past(bus_done_i, 2)
      |-> $stable(pll_num_o) && $stable(pll_den_o))
      else $error("divider moved early");
   a_timeout_to_recov: assert property (wd_timeout_o |=> s_recov_entered)
      else $error("no recovery");
   a_timeout_one_pulse: assert property (wd_timeout_o |=> !wd_timeout_o)
      else $error("time-out repeats");
   a_timeout_reset: assert property (
      wd_timeout_o && timeout_reset_enable_i |-> ##[0:1] sys_reset_o)
      else $error("no reset on time-out");
   a_reset_width: assert property ($rose(sys_reset_o) |-> s_pulse_held)
      else $error("reset pulse short");
   a_disarmed_quiet: assert property (
      !watchdog_arm_i && !$past(watchdog_arm_i) |-> !wd_timeout_o)
      else $error("time-out while disarmed");
   a_change_reset: assert property (
      freq_load_o && change_reset_enable_i |-> sys_reset_o)
      else $error("no reset on change");
   a_recov_stays: assert property (
      recovery_active_o && watchdog_arm_i |=> recovery_active_o)
      else $error("recovery dropped");
endmodule // fsw_freq_ctrl_assertions
bind fsw_freq_ctrl fsw_freq_ctrl_assertions #(.WD_SHORT_CYC(WD_SHORT_CYC),
   .WD_LONG_CYC(WD_LONG_CYC)) u_chk (.*);
`default_nettype wire

// *** bench/fsw_host_model.sv ***
/* bus host model: stages divider bytes and ends the transaction.
   assumes the caller enters xfer between falling edges. */
`timescale 1ns/1ps
`default_nettype none
module fsw_host_model (
   input  wire logic       mclk_i,
   output logic            cpu_wr_o,
   output logic            rec_wr_o,
   output logic            done_o,
   output logic [7:0]      n_o,
   output logic [6:0]      m_o,
   output logic [7:0]      rn_o,
   output logic [6:0]      rm_o
);
   initial {cpu_wr_o, rec_wr_o, done_o, n_o, m_o, rn_o, rm_o} = '0;
   // both halves of a pair in one transaction, N byte then M byte
   task automatic xfer(input logic rec, input logic [7:0] n, input logic [6:0] m,
                       input logic fin);
      @(negedge mclk_i);
      if (rec) {rn_o, rec_wr_o} = {n, 1'b1};
      else {n_o, cpu_wr_o} = {n, 1'b1};
      @(negedge mclk_i);
      if (rec) rm_o = m;
      else m_o = m;
      @(negedge mclk_i);
      {cpu_wr_o, rec_wr_o, done_o} = {2'b00, fin}; // fin=0 leaves it hanging
      @(negedge mclk_i);
      done_o = 1'b0;
   endtask
endmodule // fsw_host_model
`default_nettype wire

// *** bench/freq_select_watchdog_recovery_tb_top.sv ***
/* self-checking bench for fsw_freq_ctrl.
   assumes watchdog counts shortened to 50 and 80 cycles. */
`timescale 1ns/1ps
`default_nettype none
module freq_select_watchdog_recovery_tb_top;
   logic mclk_i = 0, rst_i = 1, prog = 0, byp = 0, rsel = 0, arm = 0, wdl = 0, tre = 0, cre = 0;
   logic [4:0] strap = 0, tsel = 0;
   logic [7:0] n, rn;
   logic [6:0] m, rm;
   logic cw, rw, dn, load, tmo, rsto, ract;
   logic [7:0] hn, hrn;
   logic [6:0] hm, hrm;
   logic [1:0] src;
   logic [4:0] ratio;
   logic [8:0] pnum, pden;
   int n_fail = 0, n_tests = 0, cyc = 0, n_tmo = 0;
   int n_load = 0, l0 = 0, k = 0;
   localparam int WD_S = 50;
   localparam int WD_L = 80;
   always #5 mclk_i = ~mclk_i;
   fsw_host_model host (.mclk_i(mclk_i), .cpu_wr_o(cw), .rec_wr_o(rw), .done_o(dn),
      .n_o(hn), .m_o(hm), .rn_o(hrn), .rm_o(hrm));
   fsw_freq_ctrl #(.WD_SHORT_CYC(WD_S), .WD_LONG_CYC(WD_L)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
      .latched_strap_inputs_i(strap), .prog_enable_i(prog), .strap_bypass_select_i(byp),
      .table_select_i(tsel), .cpu_divider_n_i(hn), .cpu_divider_m_i(hm), .cpu_div_wr_i(cw),
      .recovery_source_select_i(rsel), .recovery_divider_n_i(hrn),
      .recovery_divider_m_i(hrm), .rec_div_wr_i(rw), .bus_done_i(dn),
      .watchdog_arm_i(arm), .wd_long_scale_i(wdl), .timeout_reset_enable_i(tre),
      .change_reset_enable_i(cre), .freq_source_o(src), .ratio_select_o(ratio),
      .pll_num_o(pnum), .pll_den_o(pden), .freq_load_o(load), .recovery_active_o(ract),
      .wd_timeout_o(tmo), .sys_reset_o(rsto));
   // ****************************************************************
   // helpers
   // ****************************************************************
   // hang guard: the whole run needs well under 3000 cycles;
   // pulses counted at the falling edge, where outputs have settled
   always @(negedge mclk_i)
   begin
      cyc++;
      n_tmo += (tmo === 1'b1);
      n_load += (load === 1'b1);
      if (cyc > 5000)
      begin
         n_fail++;
         test_done();
      end
   end
   function automatic logic [8:0] plus3(input logic [7:0] v);
      return {1'b0, v} + 9'h003; // pll takes value plus three
   endfunction
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************************************
   // sequence
   // ****************************************************************
   initial
   begin
      void'($urandom(32'hbd22));
      strap = 5'($urandom);
      tsel = 5'($urandom);
      tick(3);
      rst_i = 0;
      tick(6);
      chk(9'(src), 9'h000);
      chk(9'(ratio), 9'(strap));
      chk(pnum, 9'h003);
      byp = 1;
      tick(3);
      chk(9'(src), 9'h001);
      chk(9'(ratio), 9'(tsel));
      $display("table select test done");
      prog = 1;
      for (int i = 0; i < 4; i++)
      begin
         byp = i[0];
         n = (i == 3) ? 8'hff : 8'($urandom_range(255, 97));
         m = (i == 3) ? 7'h00 : 7'($urandom_range(93, 45));
         tick(4);
         l0 = n_load;
         host.xfer(1'b0, n, m, 1'b1);
         tick(1);
         chk(pnum, plus3(n));
         chk(pden, plus3({1'b0, m}));
         chk(9'(src), 9'h002);
         chk(9'(ratio), byp ? 9'(tsel) : 9'(strap));
         chk(9'(n_load - l0), 9'h001);
      end
      host.xfer(1'b0, 8'h80, 7'h2d, 1'b0);
      tick(3);
      chk(pnum, plus3(n));
      $display("divider test done");
      {rsel, tre, arm} = 3'b111;
      rn = 8'($urandom_range(200, 100));
      rm = 7'h2d;
      host.xfer(1'b1, rn, rm, 1'b1);
      host.xfer(1'b0, n, m, 1'b1);
      for (k = 0; k < 200 && tmo !== 1'b1; k++) tick(1);
      tick(2);
      chk(9'(n_tmo), 9'h001);
      chk(9'(src), 9'h003);
      chk(pnum, plus3(rn));
      chk(9'({ract, rsto}), 9'h003);
      tick(200);
      chk(9'(n_tmo), 9'h001);
      arm = 0;
      tick(3);
      chk(9'(ract), 9'h000);
      $display("watchdog test done");
      // re-arm on the long scale with recovery taken from the straps
      {byp, rsel, tre, wdl, arm} = 5'b00011;
      tick(3);
      cre = 1;
      host.xfer(1'b0, 8'h61, 7'h5d, 1'b1);
      tick(1);
      chk(9'(rsto), 9'h001);
      cre = 0;
      for (k = 0; k < 200 && tmo !== 1'b1; k++) tick(1);
      chk(9'(k), 9'(WD_L - 1));
      tick(2);
      chk(9'(src), 9'h003);
      chk(9'(ratio), 9'(strap));
      chk(9'(rsto), 9'h000);
      chk(9'(n_tmo), 9'h002);
      $display("change reset test done");
      test_done();
   end
endmodule // freq_select_watchdog_recovery_tb_top
`default_nettype wire
